//--- rtl/sbdma_ctx.sv
// Serial-bus DMA context control and command-pointer registers
// Functional notes
// - Error halt keeps current descriptor address
// - Completion shows last address, count zero
// - Four transmit control registers
// - Timed-start enable clears once active
// - Timed start waits for cycle time
// - Run bit starts engine, resets zero
// - Wake bit resumes processing
// - Dead flag set on error halt
// - Active flag high while processing
// - Five-bit event result field
// - Four independent receive contexts
// - Many-channel ignores single channel id
// - Split select clears many and fill
// - Bit 31 selects fill storage
// - Header-keep clear strips header, trailer
module sbdma_ctx_engine
    import sbdma_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Software control
    input wire logic run_set,
    input wire logic run_clr,
    input wire logic wake,
    input wire logic timed_en,
    input wire logic [14:0] timed_value,
    input wire logic [14:0] cycle_time,
    input wire logic ptr_wr,
    input wire logic [31:0] ptr_wdata,
    input wire sbdma_evt_s evt,
    // State
    output logic run_q,
    output logic active,
    output logic dead,
    output logic timed_clr,
    output logic [4:0] code,
    output logic [31:0] ptr
);
    sbdma_state_e state_reg, state_next;
    wire start_ok = !timed_en || (cycle_time == timed_value);
    wire halt_err = (state_reg == SBDMA_RUN) && evt.err;
    wire halt_done = (state_reg == SBDMA_RUN) && evt.done;
    // Wake restarts a program whose run flag is still set
    wire resume = wake && run_q && !run_clr;
    // Descriptor advance: next 16-byte aligned descriptor
    wire adv = active && evt.step && !wake;
    wire [27:0] addr_step = ptr[31:SBDMA_CNT_W] + 28'h000_0001;

    // Next-state selection
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SBDMA_IDLE: begin
                // Run starts, wake resumes
                if (run_set || resume) begin
                    state_next = SBDMA_WAIT;
                end
            end
            SBDMA_WAIT: begin
                // Hold here until the start time matches
                if (run_clr) begin
                    state_next = SBDMA_IDLE;
                end else if (start_ok) begin
                    state_next = SBDMA_RUN;
                end
            end
            SBDMA_RUN: begin
                // Stop, error halt or normal completion
                if (run_clr || halt_err || halt_done) begin
                    state_next = SBDMA_IDLE;
                end
            end
            default: begin
                state_next = SBDMA_IDLE;
            end
        endcase
    end

    assign active = (state_reg == SBDMA_RUN);
    assign timed_clr = active && timed_en;

    // State, flags, event code and pointer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= SBDMA_IDLE;
            run_q <= 1'b0;
            dead <= 1'b0;
            code <= 5'h00;
            ptr <= SBDMA_REG_RST;
        end else if (ce) begin
            state_reg <= state_next;
            // Run flag: set by software, cleared by stop or error halt
            if (run_set) begin
                run_q <= 1'b1;
            end else if (run_clr || halt_err) begin
                run_q <= 1'b0;
            end
            // Dead flag: set on error halt, cleared by the next start
            if (run_set) begin
                dead <= 1'b0;
            end else if (halt_err) begin
                dead <= 1'b1;
            end
            // Event result of the last halt
            if (halt_err) begin
                code <= evt.code;
            end else if (halt_done) begin
                code <= SBDMA_EVT_DONE;
            end
            // Pointer: software load, completion, descriptor advance
            if (ptr_wr) begin
                ptr <= ptr_wdata;
            end else if (halt_done) begin
                ptr[SBDMA_CNT_W-1:0] <= '0;
            end else if (adv) begin
                ptr[31:SBDMA_CNT_W] <= addr_step;
            end
        end
    end
    // Wake while running does not advance; wake after completion resumes
endmodule : sbdma_ctx_engine

module sbdma_ctx
    import sbdma_pkg::*;
#(
    parameter int N_CTX = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Cycle timer and fetch engine reports
    input wire logic [14:0] cycle_time,
    input wire sbdma_evt_s ar_evt,
    input wire sbdma_evt_s [N_CTX-1:0] it_evt,
    input wire sbdma_evt_s [N_CTX-1:0] ir_evt,
    // Receive storage controls to the data path
    output logic [N_CTX-1:0] ir_fill_mode,
    output logic [N_CTX-1:0] ir_strip_header,
    output logic [N_CTX-1:0] ir_use_channel_id
);
    localparam int NE = 2 * N_CTX + 1;
    // Address phase capture
    logic wr_pend_reg;
    logic rd_wait_reg;
    logic [7:0] addr_reg;
    wire take = hsel && hready && (htrans == SBDMA_HTRANS_NONSEQ);
    // One wait state on reads: read data is registered from the captured address
    // Writes land at the end of their data phase with no wait
    assign hreadyout = !rd_wait_reg;
    assign hresp = 1'b0;

    // Address capture and data-phase flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else if (clk_en) begin
            wr_pend_reg <= take && hwrite;
            rd_wait_reg <= take && !hwrite;
            if (take) addr_reg <= haddr[7:0];
        end
    end

    // Per-context control storage: engine 0 is AR, 1..N IT, N+1..2N IR
    logic [31:0] ctrl_reg [NE];
    logic [NE-1:0] run_q, active, dead, timed_clr;
    logic [4:0] code [NE];
    logic [31:0] ptr [NE];
    logic [31:0] rd_ctrl [NE];
    logic [NE-1:0] ctrl_hit, ptr_hit;

    genvar g;
    generate
        for (g = 0; g < NE; g++) begin : g_ctx
            localparam logic [7:0] CB = (g == 0) ? SBDMA_AR_CTRL_OFF : (g <= N_CTX) ?
                8'(SBDMA_IT_CTRL_BASE + 4 * (g - 1)) : 8'(SBDMA_IR_CTRL_BASE + 4 * (g - 1 - N_CTX));
            localparam logic [7:0] PB = (g == 0) ? SBDMA_AR_CMDPTR_OFF : (g <= N_CTX) ?
                8'(SBDMA_IT_CMDPTR_BASE + 4 * (g - 1)) : 8'(SBDMA_IR_CMDPTR_BASE + 4 * (g - 1 - N_CTX));
            localparam bit IS_IR = (g > N_CTX);
            wire idle = !run_q[g] && !active[g];
            wire cw = wr_pend_reg && (addr_reg == CB);
            wire w_run = cw && hwdata[SBDMA_RUN_BIT];
            wire w_stop = cw && !hwdata[SBDMA_RUN_BIT];
            wire w_wake = cw && hwdata[SBDMA_WAKE_BIT];
            wire sbdma_evt_s ev;
            // Pick this context's report port
            if (g == 0) begin : g_ar
                assign ev = ar_evt;
            end else if (g <= N_CTX) begin : g_it
                assign ev = it_evt[g - 1];
            end else begin : g_ir
                assign ev = ir_evt[g - 1 - N_CTX];
            end
            // Start only from a stopped engine; pointer loads only while idle
            wire run_go = w_run && !run_q[g];
            wire ptr_load = wr_pend_reg && ptr_hit[g] && idle;
            wire timed_en = IS_IR ? ctrl_reg[g][SBDMA_IR_TIMED_BIT] : ctrl_reg[g][SBDMA_TIMED_EN_BIT];
            logic [31:0] cnext;
            assign ctrl_hit[g] = (addr_reg == CB);
            assign ptr_hit[g] = (addr_reg == PB);

            // Mode bits follow writes (IR only while idle, AR held at reset); hardware clears win
            always_comb begin
                cnext = ctrl_reg[g];
                if (cw && (!IS_IR || idle)) begin
                    cnext[31:16] = hwdata[31:16];
                end else if (cw && !IS_IR) begin
                    cnext[31:16] = hwdata[31:16];
                end
                if (IS_IR && cnext[SBDMA_SPLIT_BIT]) begin
                    cnext[SBDMA_MANY_BIT] = 1'b0;
                    cnext[SBDMA_FILL_BIT] = 1'b0;
                end
                if (timed_clr[g]) begin
                    if (IS_IR) cnext[SBDMA_IR_TIMED_BIT] = 1'b0;
                    else cnext[SBDMA_TIMED_EN_BIT] = 1'b0;
                end
                if (g == 0) cnext = SBDMA_REG_RST;
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) ctrl_reg[g] <= SBDMA_REG_RST;
                else if (clk_en) ctrl_reg[g] <= cnext;
            end

            // Program engine of this context
            sbdma_ctx_engine u_eng (
                .clk(hclk),
                .rstn(hresetn),
                .ce(clk_en),
                .run_set(run_go),
                .run_clr(w_stop),
                .wake(w_wake),
                .timed_en(timed_en && (g != 0)),
                .timed_value(ctrl_reg[g][SBDMA_TIMED_HI:SBDMA_TIMED_LO]),
                .cycle_time(cycle_time),
                .ptr_wr(ptr_load),
                .ptr_wdata(hwdata),
                .evt(ev),
                .run_q(run_q[g]),
                .active(active[g]),
                .dead(dead[g]),
                .timed_clr(timed_clr[g]),
                .code(code[g]),
                .ptr(ptr[g])
            );

            // Control readback: mode bits, run, dead, active, event code
            assign rd_ctrl[g] = {ctrl_reg[g][31:16], run_q[g], 2'b00, 1'b0, dead[g],
                active[g], 5'b0_0000, code[g]};
        end
        // Receive storage controls to the data path
        for (g = 0; g < N_CTX; g++) begin : g_ir_out
            assign ir_fill_mode[g] = ctrl_reg[g + 1 + N_CTX][SBDMA_FILL_BIT];
            assign ir_strip_header[g] = !ctrl_reg[g + 1 + N_CTX][SBDMA_KEEPHDR_BIT];
            assign ir_use_channel_id[g] = !ctrl_reg[g + 1 + N_CTX][SBDMA_MANY_BIT];
        end
    endgenerate

    // Read data selection
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        for (int i = 0; i < NE; i++) begin
            if (ctrl_hit[i]) begin
                rd_mux = rd_ctrl[i];
            end
            if (ptr_hit[i]) begin
                rd_mux = ptr[i];
            end
        end
    end

    // Read data loads in the wait state and stands for the closing edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && rd_wait_reg) begin
            hrdata <= rd_mux;
        end
    end
endmodule : sbdma_ctx

//--- rtl/sbdma_pkg.sv
// Package for the serial-bus DMA context control block
package sbdma_pkg;
    // Register byte offsets
    localparam logic [7:0] SBDMA_AR_CMDPTR_OFF = 8'h00;
    localparam logic [7:0] SBDMA_IT_CTRL_BASE = 8'h10;
    localparam logic [7:0] SBDMA_IT_CMDPTR_BASE = 8'h20;
    localparam logic [7:0] SBDMA_IR_CTRL_BASE = 8'h30;
    localparam logic [7:0] SBDMA_IR_CMDPTR_BASE = 8'h40;
    localparam logic [7:0] SBDMA_AR_CTRL_OFF = 8'h50;
    // Control field positions
    localparam int SBDMA_TIMED_EN_BIT = 31;
    localparam int SBDMA_TIMED_HI = 30;
    localparam int SBDMA_TIMED_LO = 16;
    localparam int SBDMA_RUN_BIT = 15;
    localparam int SBDMA_WAKE_BIT = 12;
    localparam int SBDMA_DEAD_BIT = 11;
    localparam int SBDMA_ACTIVE_BIT = 10;
    localparam int SBDMA_EVT_HI = 4;
    localparam int SBDMA_FILL_BIT = 31;
    localparam int SBDMA_KEEPHDR_BIT = 30;
    localparam int SBDMA_IR_TIMED_BIT = 29;
    localparam int SBDMA_MANY_BIT = 28;
    localparam int SBDMA_SPLIT_BIT = 27;
    localparam int SBDMA_CNT_W = 4;
    // Reset values and event codes
    localparam logic [31:0] SBDMA_REG_RST = 32'h0000_0000;
    localparam logic [4:0] SBDMA_EVT_DONE = 5'h11;
    localparam logic [4:0] SBDMA_EVT_ERR = 5'h0e;
    localparam logic [1:0] SBDMA_HTRANS_NONSEQ = 2'h2;

    // Engine states
    typedef enum logic [1:0] {
        SBDMA_IDLE = 2'b00,
        SBDMA_WAIT = 2'b01,
        SBDMA_RUN = 2'b10
    } sbdma_state_e;

    // Descriptor progress report from the fetch engine
    typedef struct packed {
        logic step;
        logic done;
        logic err;
        logic [4:0] code;
    } sbdma_evt_s;
endpackage : sbdma_pkg

//--- test/sbdma_ctx_props.sv
// Assertions on the DMA context control block
module sbdma_ctx_props
    import sbdma_pkg::*;
#(
    parameter int N_CTX = 4
) (
    // Bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic hready,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] haddr,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    // Reports and storage controls
    input wire sbdma_evt_s ar_evt,
    input wire sbdma_evt_s [N_CTX-1:0] ir_evt,
    input wire logic [N_CTX-1:0] ir_fill_mode,
    input wire logic [N_CTX-1:0] ir_strip_header,
    input wire logic [N_CTX-1:0] ir_use_channel_id
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic v_reg, w_reg, run_reg, dead_reg, wrote_reg, done_reg;
    logic [7:0] a_reg;
    // Data-phase decode
    wire wr = v_reg && w_reg && hready;
    wire rd = v_reg && !w_reg && hready;
    wire ir0_wr = wr && a_reg == SBDMA_IR_CTRL_BASE;
    // Track transfers and receive context zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {v_reg, w_reg, run_reg, dead_reg, wrote_reg, done_reg, a_reg} <= '0;
        end else begin
            if (hready) begin
                v_reg <= hsel && htrans == SBDMA_HTRANS_NONSEQ;
                w_reg <= hwrite;
                a_reg <= haddr[7:0];
            end
            wrote_reg <= wrote_reg | wr;
            run_reg <= ir0_wr ? hwdata[SBDMA_RUN_BIT] : run_reg & ~ir_evt[0].err;
            dead_reg <= (dead_reg & ~ir0_wr) | (run_reg & ir_evt[0].err);
            done_reg <= (done_reg & ~(wr && a_reg == 8'h00)) | ar_evt.done;
        end
    end
    // Write to an idle context, read of one address
    sequence idle_wr;
        ir0_wr && !run_reg;
    endsequence
    sequence rd_at(logic [7:0] a);
        rd && a_reg == a;
    endsequence
    AST_FILL: assert property (idle_wr |=>
        ir_fill_mode[0] == $past(hwdata[31] & ~hwdata[27])) else $error("bad fill mode");
    AST_STRIP: assert property (idle_wr |=>
        ir_strip_header[0] == !$past(hwdata[30])) else $error("bad header strip");
    AST_CHAN: assert property (idle_wr |=>
        ir_use_channel_id[0] == !$past(hwdata[28] & ~hwdata[27])) else $error("bad channel use");
    AST_HOLD: assert property (ir0_wr && run_reg |=>
        $stable(ir_fill_mode[0]) && $stable(ir_strip_header[0])) else $error("mode changed in run");
    AST_STABLE: assert property (!wr |=> $stable(ir_fill_mode))
        else $error("fill mode moved alone");
    AST_RST_RD: assert property (!wrote_reg && rd |-> hrdata == 32'h0000_0000)
        else $error("not reset value");
    AST_AR_DONE: assert property (done_reg ##0 rd_at(SBDMA_AR_CMDPTR_OFF) |->
        hrdata[3:0] == 4'h0) else $error("count not zero");
    AST_DEAD: assert property (dead_reg ##0 rd_at(SBDMA_IR_CTRL_BASE) |->
        hrdata[11] && !hrdata[15]) else $error("dead flag missing");
endmodule : sbdma_ctx_props

bind sbdma_ctx sbdma_ctx_props #(.N_CTX(N_CTX)) u_props (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .hready(hready), .htrans(htrans), .hwrite(hwrite), .haddr(haddr),
    .hwdata(hwdata), .hrdata(hrdata), .ar_evt(ar_evt), .ir_evt(ir_evt),
    .ir_fill_mode(ir_fill_mode), .ir_strip_header(ir_strip_header),
    .ir_use_channel_id(ir_use_channel_id));

//--- test/sbdma_fetch_model.sv
// Fetch engine stand-in reporting descriptor progress
module sbdma_fetch_model
    import sbdma_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Progress pulses
    output sbdma_evt_s ar_evt,
    output sbdma_evt_s [3:0] it_evt,
    output sbdma_evt_s [3:0] ir_evt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet between reports
    initial begin
        ar_evt = '0;
        it_evt = '0;
        ir_evt = '0;
    end
    // One-cycle report after dly edges; g picks AR, IT or IR
    task automatic send(input int g, input int i, input sbdma_evt_s e, input int dly);
        repeat (dly) @(posedge hclk);
        case (g)
            0: ar_evt <= e;
            1: it_evt[i] <= e;
            default: ir_evt[i] <= e;
        endcase
        @(posedge hclk);
        ar_evt <= '0;
        it_evt <= '0;
        ir_evt <= '0;
    endtask : send
endmodule : sbdma_fetch_model

//--- test/sbdma_ctx_tb.sv
// Self-checking bench for the DMA context control block
module sbdma_ctx_tb
    import sbdma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, rdy;
    logic [1:0] htrans = 2'h0;
    logic [14:0] cycle_time = 15'h0000;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r, v;
    logic [3:0] fill, strip, usech;
    logic [31:0] mdl [0:31];
    logic [31:0] pat [0:3] = '{32'hd000_0000, 32'h8000_0000, 32'h4000_0000, 32'hd800_0000};
    sbdma_evt_s ar_evt;
    sbdma_evt_s [3:0] it_evt, ir_evt;
    int miscompares = 0, n_tests = 0, seed = 32'h29b1c9b2;
    sbdma_ctx #(.N_CTX(4)) uut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(), .cycle_time(cycle_time),
        .ar_evt(ar_evt), .it_evt(it_evt), .ir_evt(ir_evt), .ir_fill_mode(fill),
        .ir_strip_header(strip), .ir_use_channel_id(usech));
    sbdma_fetch_model fm (.hclk(hclk), .ar_evt(ar_evt), .it_evt(it_evt), .ir_evt(ir_evt));
    // Clock
    always #2.5 hclk = ~hclk;
    // Helpers: pointer address, expected storage controls
    function automatic logic [7:0] adr(input int k);
        return (k == 0) ? 8'h00 : 8'(k < 5 ? 28 + 4 * k : 44 + 4 * k);
    endfunction : adr
    function automatic logic [31:0] mode_of(input logic [31:0] p);
        return {29'h0000_0000, p[31] & ~p[27], ~p[30], ~(p[28] & ~p[27])};
    endfunction : mode_of
    // Masked comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_tests++;
        if ((got & m) !== (exp & m)) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One AHB single transfer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= SBDMA_HTRANS_NONSEQ;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        @(posedge hclk);
        while (rdy !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (rdy !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask : xfer
    // Register write and model-checked read
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        mdl[a[6:2]] = d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m);
        xfer(1'b0, a, 32'h0000_0000);
        chk(r, mdl[a[6:2]], m);
    endtask : rd
    // Verdict
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog
    initial begin
        #20000;
        miscompares++;
        tally_and_finish();
    end
    // Scenarios
    initial begin
        for (int k = 0; k < 32; k++) mdl[k] = 32'h0000_0000;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int k = 0; k < 25; k++) rd(8'(4 * k), 32'hffff_ffff);
        $display("end reset values");
        for (int k = 0; k < 9; k++) begin
            v = $random(seed);
            v[3:0] = (k == 0 || k > 4) ? 4'h1 : 4'(2 + ($unsigned($random(seed)) % 7));
            wr(adr(k), v);
        end
        for (int k = 0; k < 9; k++) rd(adr(k), 32'hffff_ffff);
        $display("end pointers");
        for (int i = 0; i < 4; i++) foreach (pat[j]) begin
            wr(8'h30 + 8'(4 * i), pat[j]);
            @(posedge hclk);
            chk(32'({fill[i], strip[i], usech[i]}), mode_of(pat[j]), 32'h0000_0007);
        end
        $display("end storage modes");
        wr(8'h10, 32'h8005_8000);
        repeat (3) @(posedge hclk);
        rd(8'h10, 32'h8000_8c00);
        cycle_time <= 15'h0005;
        repeat (3) @(posedge hclk);
        mdl[4] = 32'h0005_8400;
        rd(8'h10, 32'h8000_8c00);
        xfer(1'b1, 8'h20, 32'h1234_5672);
        rd(8'h20, 32'hffff_ffff);
        fm.send(1, 0, '{1'b1, 1'b0, 1'b0, 5'h00}, 2);
        fm.send(1, 0, '{1'b0, 1'b1, 1'b0, 5'h00}, 2);
        @(posedge hclk);
        mdl[8] = {mdl[8][31:4] + 28'h000_0001, 4'h0};
        mdl[4] = {27'h000_0000, SBDMA_EVT_DONE};
        rd(8'h20, 32'hffff_ffff);
        rd(8'h10, 32'h0000_001f);
        $display("end timed transmit");
        wr(8'h30, 32'h8000_8000);
        repeat (3) @(posedge hclk);
        xfer(1'b1, 8'h30, 32'h4800_8000);
        @(posedge hclk);
        chk(32'({fill[0], strip[0], usech[0]}), mode_of(32'h8000_0000), 32'h0000_0007);
        fm.send(2, 0, '{1'b1, 1'b0, 1'b0, 5'h00}, 2);
        fm.send(2, 0, '{1'b0, 1'b0, 1'b1, SBDMA_EVT_ERR}, 5);
        @(posedge hclk);
        mdl[12] = {20'h0_0000, 7'h40, SBDMA_EVT_ERR};
        rd(8'h30, 32'h0000_8c1f);
        mdl[16] = {mdl[16][31:4] + 28'h000_0001, 4'h0};
        rd(8'h40, 32'hffff_fff0);
        $display("end receive error");
        wr(8'h50, 32'h0000_8000);
        repeat (3) @(posedge hclk);
        fm.send(0, 0, '{1'b0, 1'b1, 1'b0, 5'h00}, 2);
        @(posedge hclk);
        mdl[0][3:0] = 4'h0;
        rd(8'h00, 32'hffff_ffff);
        wr(8'h50, 32'h0000_9000);
        mdl[20] = 32'h0000_0400;
        repeat (3) @(posedge hclk);
        rd(8'h50, 32'h0000_0400);
        $display("end async completion");
        tally_and_finish();
    end
endmodule : sbdma_ctx_tb
